// ===== common/pbd_consts.svh
`ifndef PBD_CONSTS_SVH
`define PBD_CONSTS_SVH

// register byte offsets
`define PBD_OFF_SELECT 12'h284
`define PBD_OFF_READOUT 12'h288
`define PBD_OFF_CAP_FLAGS 12'h28C
`define PBD_OFF_VALUE_BASE 12'h300
`define PBD_OFF_VALUE_LAST 12'h31C
`define PBD_OFF_SW_CONTROL 12'h404
`define PBD_OFF_SW_STATUS 12'h400

// field positions
`define PBD_SEL_MSB 7
`define PBD_SA_BIT 0
`define PBD_UNLOCK_BIT 0
`define PBD_MODE_MSB 3
`define PBD_CCLK_BIT 5

// reset values and value entry count
`define PBD_SELECT_RST 8'h00
`define PBD_SA_RST 1'b0
`define PBD_UNLOCK_RST 1'b0
`define PBD_VALUE_RST 32'h0000_0000
`define PBD_NUM_VALUES 8

`endif

// ===== common/pbd_pkg.sv
package pbd_pkg;

    typedef struct packed {
        logic [11:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } pbd_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } pbd_wb_rsp_t;

    typedef struct packed {
        logic [3:0] operating_mode_code;
        logic downstream_common_clock;
    } pbd_strap_t;

endpackage

// ===== sim/pbd_power_budget_regs_asserts.sv
`timescale 1ns/10ps
module pbd_power_budget_regs_asserts
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic fundamental_reset_n_i,
    input wire pbd_pkg::pbd_strap_t strap_i,
    input wire pbd_pkg::pbd_wb_req_t wb_req_i,
    input wire pbd_pkg::pbd_wb_rsp_t wb_rsp_o,
    input wire logic system_allocated_flag_o,
    input wire logic value_unlock_o
);
    import pbd_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire tk = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    wire wr = tk && wb_req_i.we && wb_req_i.sel[0];
    wire rd = tk && !wb_req_i.we;
    wire [11:0] a = wb_req_i.adr;
    ////////////////////////////////////////////////////////////////////////
    property p_ans; tk |=> wb_rsp_o.ack; endproperty
    a_ans: assert property (p_ans) else $error("ack late");
    property p_one; wb_rsp_o.ack |=> !wb_rsp_o.ack; endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_dz; !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000; endproperty
    a_dz: assert property (p_dz) else $error("data off ack");
    property p_sa; rd && a == 12'h28C |=>
        wb_rsp_o.dat == {31'h0, system_allocated_flag_o}; endproperty
    a_sa: assert property (p_sa) else $error("flag read");
    property p_saw; wr && a == 12'h28C |=>
        system_allocated_flag_o == $past(wb_req_i.dat[0]); endproperty
    a_saw: assert property (p_saw) else $error("flag write");
    property p_hold; !(wr && a == 12'h28C) |=>
        $stable(system_allocated_flag_o); endproperty
    a_hold: assert property (p_hold) else $error("flag moved");
    property p_ul; wr && a == 12'h404 |=>
        value_unlock_o == $past(wb_req_i.dat[0]); endproperty
    a_ul: assert property (p_ul) else $error("unlock write");
    // straps are held static by the bench once captured
    property p_st; rd && a == 12'h400 |=> wb_rsp_o.dat == {26'h0,
        strap_i.downstream_common_clock, 1'b0, strap_i.operating_mode_code};
    endproperty
    a_st: assert property (p_st) else $error("status");
endmodule
////////////////////////////////////////////////////////////////////////////
bind pbd_power_budget_regs pbd_power_budget_regs_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i),
    .fundamental_reset_n_i(fundamental_reset_n_i),
    .strap_i(strap_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .system_allocated_flag_o(system_allocated_flag_o),
    .value_unlock_o(value_unlock_o));

// ===== sim/pbd_power_budget_regs_bench.sv
`timescale 1ns/10ps
module pbd_power_budget_regs_bench;
    import pbd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic frst_n = 1'b1;
    pbd_strap_t strap = '0;
    pbd_wb_req_t req = '0;
    pbd_wb_rsp_t rsp;
    logic sa;
    logic ul;
    int fail_count = 0;
    int n_tests = 0;
    pbd_power_budget_regs dut (.clk_i(clk_i), .rst_i(rst_i),
        .fundamental_reset_n_i(frst_n), .strap_i(strap), .wb_req_i(req),
        .wb_rsp_o(rsp), .system_allocated_flag_o(sa), .value_unlock_o(ul));
    initial
    begin
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            $display("BAD t=%0t got %h exp %h", $time, g, e);
            fail_count++;
        end
    endtask
    // holds the request until ack, then idles a cycle before the next
    task automatic bus(input logic [11:0] a, input logic [31:0] d,
        input logic w, input logic [31:0] e);
        int n;
        req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (rsp.ack !== 1'b1 && n < 20);
        chk({31'h0, rsp.ack}, 32'h0000_0001);
        if (!w)
        begin
            chk(rsp.dat, e);
        end
        req <= '0;
        @(posedge clk_i);
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk_i);
            strap <= '{m[3:0], m[0]};
            frst_n <= 1'b0;
            repeat (8) @(posedge clk_i);
            frst_n <= 1'b1;
            repeat (4) @(posedge clk_i);
            bus(12'h400, 0, 0, {26'h0, m[0], 1'b0, m[3:0]});
        end
        bus(12'h28C, 0, 0, 0);
        bus(12'h28C, 32'hFFFF_FFFF, 1, 0);
        bus(12'h28C, 0, 0, 1);
        chk({31'h0, sa}, 1);
        bus(12'h300, 32'h1234_5678, 1, 0);
        bus(12'h300, 0, 0, 0);
        bus(12'h404, 1, 1, 0);
        chk({31'h0, ul}, 1);
        for (int i = 0; i < 8; i++)
            bus(12'(12'h300 + 4 * i), 32'(32'hA5A5_0000 + i), 1, 0);
        for (int i = 0; i < 8; i++)
        begin
            bus(12'h284, 32'(i), 1, 0);
            bus(12'h288, 0, 0, 32'(32'hA5A5_0000 + i));
            bus(12'(12'h300 + 4 * i), 0, 0, 32'(32'hA5A5_0000 + i));
        end
        bus(12'h284, 32'h0000_0108, 1, 0);
        bus(12'h284, 0, 0, 32'h0000_0008);
        bus(12'h288, 0, 0, 0);
        bus(12'h284, 32'h0000_00FF, 1, 0);
        bus(12'h288, 0, 0, 0);
        bus(12'h404, 0, 1, 0);
        bus(12'h31C, 32'hDEAD_BEEF, 1, 0);
        bus(12'h31C, 0, 0, 32'hA5A5_0007);
        bus(12'h2F0, 0, 0, 0);
        close_out();
    end
endmodule

// ===== verilog/pbd_power_budget_regs.sv
`timescale 1ns/10ps
`include "pbd_consts.svh"

// Overview of operation
// - readout returns value entry picked by select
// - out-of-range select reads readout as zero
// - select is bits 7:0, above 7 zero
// - capability bit 0 is system allocated flag
// - eight 32-bit value entries from 0x300
// - value entries writable only while unlocked
// - status bits 3:0 report strapped mode
// - status bit 5 holds sampled common clock

module pbd_power_budget_regs
#(
    parameter int NUM_VALUES = `PBD_NUM_VALUES
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // configuration pins, followed during fundamental reset and held from its release
    input wire logic fundamental_reset_n_i,
    input wire pbd_pkg::pbd_strap_t strap_i,
    // wishbone slave
    input wire pbd_pkg::pbd_wb_req_t wb_req_i,
    output pbd_pkg::pbd_wb_rsp_t wb_rsp_o,
    // state shown to the switch core
    output logic system_allocated_flag_o,
    output logic value_unlock_o
);
    import pbd_pkg::*;

    typedef struct packed {
        logic rst_n_s1;
        logic rst_n_s2;
        pbd_strap_t strap_s1;
        pbd_strap_t strap_s2;
        pbd_strap_t strap_held;
        logic [`PBD_SEL_MSB:0] value_select;
        logic system_allocated_flag;
        logic value_unlock;
        logic [NUM_VALUES-1:0][31:0] value_word;
        logic [31:0] rdata;
        logic ack;
    } pbd_state_t;

    pbd_state_t state_reg;
    pbd_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // decode

    logic access;
    logic wr_stb;
    logic [31:0] wmask;
    logic value_hit;
    logic [2:0] value_idx;
    logic [31:0] readout;

    assign access = wb_req_i.cyc && wb_req_i.stb && !state_reg.ack;
    assign wr_stb = access && wb_req_i.we;
    assign value_hit = (wb_req_i.adr >= `PBD_OFF_VALUE_BASE)
        && (wb_req_i.adr <= `PBD_OFF_VALUE_LAST);
    assign value_idx = wb_req_i.adr[4:2];

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_mask
            assign wmask[gb*8 +: 8] = {8{wb_req_i.sel[gb]}};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // value entries, one write path per entry

    logic [NUM_VALUES-1:0] entry_we;
    logic [NUM_VALUES-1:0][31:0] entry_next;

    genvar ge;
    generate
        for (ge = 0; ge < NUM_VALUES; ge++)
        begin : g_entry
            // locked entries silently drop the write but still ack
            assign entry_we[ge] = wr_stb && value_hit
                && (value_idx == 3'(ge)) && state_reg.value_unlock;
            assign entry_next[ge] = entry_we[ge]
                ? ((state_reg.value_word[ge] & ~wmask)
                | (wb_req_i.dat & wmask))
                : state_reg.value_word[ge];
        end
    endgenerate

    // only the low three select bits can name an entry; any higher bit set
    // means the index is past the array
    always_comb
    begin
        if (state_reg.value_select < 8'(NUM_VALUES))
        begin
            readout = state_reg.value_word[state_reg.value_select[2:0]];
        end
        else
        begin
            readout = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_next = state_reg;
        state_next.rst_n_s1 = fundamental_reset_n_i;
        state_next.rst_n_s2 = state_reg.rst_n_s1;
        state_next.strap_s1 = strap_i;
        state_next.strap_s2 = state_reg.strap_s1;
        // straps are followed while reset is low and frozen at release,
        // trusting the board to keep them static afterwards
        if (!state_reg.rst_n_s2)
        begin
            state_next.strap_held = state_reg.strap_s2;
        end
        state_next.ack = access;
        state_next.rdata = 32'h0000_0000;
        state_next.value_word = entry_next;
        if (access && !wb_req_i.we)
        begin
            unique case (wb_req_i.adr)
                `PBD_OFF_SELECT:
                    state_next.rdata = {24'h00_0000, state_reg.value_select};
                `PBD_OFF_READOUT:
                    state_next.rdata = readout;
                `PBD_OFF_CAP_FLAGS:
                    state_next.rdata = {31'h0000_0000,
                        state_reg.system_allocated_flag};
                `PBD_OFF_SW_CONTROL:
                    state_next.rdata = {31'h0000_0000,
                        state_reg.value_unlock};
                `PBD_OFF_SW_STATUS:
                    state_next.rdata = {26'h000_0000,
                        state_reg.strap_held.downstream_common_clock, 1'b0,
                        state_reg.strap_held.operating_mode_code};
                default:
                begin
                    if (value_hit)
                    begin
                        state_next.rdata = state_reg.value_word[value_idx];
                    end
                end
            endcase
        end
        if (wr_stb)
        begin
            unique case (wb_req_i.adr)
                `PBD_OFF_SELECT:
                begin
                    if (wb_req_i.sel[0])
                    begin
                        state_next.value_select = wb_req_i.dat[7:0];
                    end
                end
                `PBD_OFF_CAP_FLAGS:
                begin
                    if (wb_req_i.sel[0])
                    begin
                        state_next.system_allocated_flag =
                            wb_req_i.dat[`PBD_SA_BIT];
                    end
                end
                `PBD_OFF_SW_CONTROL:
                begin
                    if (wb_req_i.sel[0])
                    begin
                        state_next.value_unlock =
                            wb_req_i.dat[`PBD_UNLOCK_BIT];
                    end
                end
                default:
                begin
                    // value entries are written through g_entry
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.value_select <= `PBD_SELECT_RST;
            state_reg.system_allocated_flag <= `PBD_SA_RST;
            state_reg.value_unlock <= `PBD_UNLOCK_RST;
            state_reg.value_word <= {NUM_VALUES{`PBD_VALUE_RST}};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wb_rsp_o.dat = state_reg.rdata;
    assign wb_rsp_o.ack = state_reg.ack;
    assign system_allocated_flag_o = state_reg.system_allocated_flag;
    assign value_unlock_o = state_reg.value_unlock;

endmodule
